/* common/msb_pkg.sv */
// Purpose: shared constants for the strobe bus slave port
// Assumes: strobe bus pins sampled synchronously to clk
// Notes: status codes are plain choices of this design
package msb_pkg;
   localparam int MSB_AD_W = 16;
   localparam int MSB_ST_W = 4;
   localparam int MSB_MEM_WORDS = 16;
   localparam logic [3:0] MSB_ST_INTERNAL = 4'h0;
   localparam logic [3:0] MSB_ST_REFRESH = 4'h1;
   localparam logic [3:0] MSB_ST_IO = 4'h2;
   localparam logic [3:0] MSB_ST_IRQ_ACK = 4'h5;
   localparam logic [3:0] MSB_ST_MEM_NORMAL_DATA = 4'h8;
   localparam logic [3:0] MSB_ST_MEM_NORMAL_PROG = 4'h9;
   localparam logic [3:0] MSB_ST_MEM_SYS_DATA = 4'hA;
   localparam logic [3:0] MSB_ST_MEM_SYS_PROG = 4'hB;
   localparam logic [15:0] MSB_IO_BASE = 16'hFF00;
   localparam logic [15:0] MSB_IO_MASK = 16'hFF00;
   localparam logic [15:0] MSB_RESET_DATA = 16'h0000;
   typedef enum logic [1:0] {MSB_IDLE, MSB_ADDR, MSB_DATA, MSB_DONE} msb_phase_t;
endpackage

/* logic/msb_slave_port.sv */
// Purpose: slave port of a multiplexed address/data strobe bus
// Assumes: all pins synchronous to clk; testbench resolves wires
// Notes: ad_oe_n low while driving; request line open drain
module msb_slave_port
   import msb_pkg::*;
#(
   parameter int WORD_BUS = 1,
   parameter int MEM_WORDS = MSB_MEM_WORDS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic address_strobe_n,
   input wire logic data_strobe_n,
   input wire logic read_not_write,
   input wire logic byte_not_word,
   input wire logic [MSB_ST_W-1:0] status,
   input wire logic [MSB_AD_W-1:0] ad_in,
   output logic [MSB_AD_W-1:0] ad_out,
   output logic ad_oe_n,
   input wire logic irq_source,
   output logic irq_oe_n,
   input wire logic chain_enable_in,
   output logic chain_enable_out,
   input wire logic want_resource,
   output logic shared_resource_request_oe_n,
   input wire logic shared_resource_sense_n,
   input wire logic resource_ack_in_n,
   output logic resource_ack_out_n,
   input wire logic bus_grant_in_n,
   output logic resource_granted,
   output logic irq_acknowledge_n,
   output logic bus_reset
);
   localparam int IDX_W = $clog2(MEM_WORDS);

   typedef struct packed {
      msb_phase_t phase;
      logic [MSB_AD_W-1:0] addr;
      logic [MSB_ST_W-1:0] st;
      logic rnw;
      logic bnw;
      logic ack_n;
      logic io_wait;
      logic drive;
      logic [MSB_AD_W-1:0] rdata;
      logic pend;
      logic req;
      logic [MEM_WORDS*8-1:0] bank_hi;
      logic [MEM_WORDS*8-1:0] bank_lo;
   } msb_state_t;

   msb_state_t s_reg, s_next;
   logic strobe_reset;
   logic is_mem, is_io, hit;
   logic [IDX_W-1:0] idx;
   logic [7:0] rd_hi, rd_lo;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   always_comb begin
      // strobe based reset sources
      strobe_reset = (!address_strobe_n && !data_strobe_n && bus_grant_in_n)
         || (!address_strobe_n && !data_strobe_n);
      is_mem = s_reg.st[3];
      is_io = (s_reg.st == MSB_ST_IO) && ((s_reg.addr & MSB_IO_MASK) == MSB_IO_BASE);
      hit = is_mem || is_io;
      idx = WORD_BUS != 0 ? s_reg.addr[IDX_W:1] : s_reg.addr[IDX_W-1:0];
      rd_hi = s_reg.bank_hi[idx*8 +: 8];
      rd_lo = s_reg.bank_lo[idx*8 +: 8];
   end

   // ------------------------------------------------------------
   // transaction sequencer
   // ------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      case (s_reg.phase)
         MSB_IDLE: begin
            s_next.drive = 1'b0;
            if (!address_strobe_n) begin
               s_next.phase = MSB_ADDR;
            end
         end
         MSB_ADDR: begin
            if (address_strobe_n) begin
               s_next.addr = ad_in;
               s_next.st = status;
               s_next.rnw = read_not_write;
               s_next.bnw = byte_not_word;
               s_next.ack_n = (status != MSB_ST_IRQ_ACK);
               s_next.io_wait = (status == MSB_ST_IO);
               s_next.phase = MSB_DATA;
            end
         end
         MSB_DATA: begin
            if (!address_strobe_n) begin
               // data strobe stayed high: null, new address phase
               s_next.phase = MSB_ADDR;
               s_next.drive = 1'b0;
            end else if (!data_strobe_n) begin
               if (s_reg.st == MSB_ST_INTERNAL || s_reg.st == MSB_ST_REFRESH) begin
                  s_next.drive = 1'b0;
               end else if (s_reg.io_wait) begin
                  s_next.io_wait = 1'b0;
               end else if (hit && s_reg.rnw) begin
                  s_next.drive = 1'b1;
                  if (WORD_BUS == 0 || is_io) begin
                     // byte data always on low lines
                     s_next.rdata = {8'h00, (WORD_BUS != 0 && s_reg.addr[0]) ? rd_lo : rd_hi};
                     if (WORD_BUS == 0) begin
                        s_next.rdata = {8'h00, rd_lo};
                     end
                  end else begin
                     s_next.rdata = {rd_hi, rd_lo};
                  end
                  s_next.phase = MSB_DONE;
               end else if (hit && !s_reg.rnw && is_mem) begin
                  if (WORD_BUS == 0) begin
                     s_next.bank_lo[idx*8 +: 8] = ad_in[7:0];
                  end else if (s_reg.bnw) begin
                     // single byte: only bank picked by A0
                     if (s_reg.addr[0]) begin
                        s_next.bank_lo[idx*8 +: 8] = ad_in[7:0];
                     end else begin
                        s_next.bank_hi[idx*8 +: 8] = ad_in[15:8];
                     end
                  end else begin
                     s_next.bank_hi[idx*8 +: 8] = ad_in[15:8];
                     s_next.bank_lo[idx*8 +: 8] = ad_in[7:0];
                  end
                  s_next.phase = MSB_DONE;
               end else begin
                  s_next.phase = MSB_DONE;
               end
            end
         end
         MSB_DONE: begin
            if (data_strobe_n) begin
               s_next.drive = 1'b0;
               s_next.ack_n = 1'b1;
               s_next.phase = MSB_IDLE;
            end
         end
         default: s_next.phase = MSB_IDLE;
      endcase
      // interrupt pending: set wins over acknowledge clear
      if (s_reg.phase == MSB_DATA && !data_strobe_n && !s_reg.ack_n && chain_enable_in
            && s_reg.pend) begin
         s_next.pend = 1'b0;
      end
      if (irq_source) begin
         s_next.pend = 1'b1;
      end
      s_next.req = want_resource;
   end

   always_ff @(posedge clk) begin
      if (!rst_n || strobe_reset) begin
         s_reg.phase <= MSB_IDLE;
         s_reg.addr <= MSB_RESET_DATA;
         s_reg.st <= MSB_ST_INTERNAL;
         s_reg.rnw <= 1'b1;
         s_reg.bnw <= 1'b0;
         s_reg.ack_n <= 1'b1;
         s_reg.io_wait <= 1'b0;
         s_reg.drive <= 1'b0;
         s_reg.rdata <= MSB_RESET_DATA;
         s_reg.pend <= 1'b0;
         s_reg.req <= 1'b0;
         s_reg.bank_hi <= s_reg.bank_hi;
         s_reg.bank_lo <= s_reg.bank_lo;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // pins
   // ------------------------------------------------------------
   always_comb begin
      ad_out = s_reg.rdata;
      ad_oe_n = !(s_reg.drive && !data_strobe_n);
      irq_oe_n = !(s_reg.pend && chain_enable_in && s_reg.ack_n);
      chain_enable_out = chain_enable_in && !s_reg.pend;
      shared_resource_request_oe_n = !s_reg.req;
      resource_granted = s_reg.req && !shared_resource_sense_n
         && !resource_ack_in_n;
      resource_ack_out_n = resource_ack_in_n || s_reg.req;
      irq_acknowledge_n = s_reg.ack_n;
      bus_reset = strobe_reset;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_no_drive_idle;
      @(posedge clk) disable iff (!rst_n)
         data_strobe_n |-> ad_oe_n;
   endproperty
   a_no_drive_idle: assert property (p_no_drive_idle) else $error("drove with strobe high");

   property p_null_no_drive;
      @(posedge clk) disable iff (!rst_n)
         (s_reg.st == MSB_ST_REFRESH && s_reg.phase == MSB_DATA) |=> !s_reg.drive;
   endproperty
   a_null_no_drive: assert property (p_null_no_drive) else $error("null cycle drove");

   property p_read_drives;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         (s_reg.phase == MSB_DATA && address_strobe_n && !data_strobe_n && is_mem
          && s_reg.rnw) |=> s_reg.drive;
   endproperty
   a_read_drives: assert property (p_read_drives) else $error("memory read not driven");

   property p_hold_until_rise;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         (s_reg.drive && !data_strobe_n) |=> (s_reg.drive || $past(data_strobe_n));
   endproperty
   a_hold_until_rise: assert property (p_hold_until_rise) else $error("data dropped early");

   property p_irq_pin;
      @(posedge clk) disable iff (!rst_n)
         !irq_oe_n |-> (s_reg.pend && chain_enable_in);
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("request without pending");

   property p_chain_low;
      @(posedge clk) disable iff (!rst_n)
         (!chain_enable_in || s_reg.pend) |-> !chain_enable_out;
   endproperty
   a_chain_low: assert property (p_chain_low) else $error("enable out wrong");

   property p_strobe_reset;
      @(posedge clk) disable iff (!rst_n)
         (!address_strobe_n && !data_strobe_n) |=> (s_reg.phase == MSB_IDLE && !s_reg.drive);
   endproperty
   a_strobe_reset: assert property (p_strobe_reset) else $error("strobe reset ignored");

   property p_ack_chain;
      @(posedge clk) disable iff (!rst_n)
         resource_ack_in_n |-> resource_ack_out_n;
   endproperty
   a_ack_chain: assert property (p_ack_chain) else $error("ack out without ack in");

   property p_oe_only_read;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         !ad_oe_n |-> (s_reg.rnw && hit && s_reg.phase == MSB_DONE);
   endproperty
   a_oe_only_read: assert property (p_oe_only_read) else $error("drove outside a read");

   property p_drive_to_rise;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         !ad_oe_n |=> (data_strobe_n || (!ad_oe_n && $stable(ad_out)));
   endproperty
   a_drive_to_rise: assert property (p_drive_to_rise) else $error("read data not held");

   property p_io_wait;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         (s_reg.phase == MSB_DATA && address_strobe_n && !data_strobe_n && s_reg.io_wait)
            |=> !s_reg.drive;
   endproperty
   a_io_wait: assert property (p_io_wait) else $error("io answered early");

   property p_ack_latch;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         (s_reg.phase == MSB_ADDR && address_strobe_n && status == MSB_ST_IRQ_ACK)
            |=> !irq_acknowledge_n;
   endproperty
   a_ack_latch: assert property (p_ack_latch) else $error("acknowledge not latched");

   property p_irq_sets;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         irq_source |=> (!irq_oe_n || !chain_enable_in || !irq_acknowledge_n);
   endproperty
   a_irq_sets: assert property (p_irq_sets) else $error("pending source not requesting");

   property p_req_pin;
      @(posedge clk) disable iff (!rst_n || strobe_reset)
         want_resource |=> !shared_resource_request_oe_n;
   endproperty
   a_req_pin: assert property (p_req_pin) else $error("resource request not driven");
endmodule

/* sim/msb_master_model.sv */
// Purpose: bus master model for the strobe bus slave port
// Assumes: slave drives the ad lines while ad_oe_n is low
// Notes: released lines toggle each cycle; probe sampled with data
module msb_master_model
   import msb_pkg::*;
(
   input wire logic clk,
   input wire logic [MSB_AD_W-1:0] ad_out,
   input wire logic ad_oe_n,
   input wire logic [1:0] probe,
   output logic address_strobe_n,
   output logic data_strobe_n,
   output logic read_not_write,
   output logic byte_not_word,
   output logic [MSB_ST_W-1:0] status,
   output logic [MSB_AD_W-1:0] ad_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic drv_reg = 1'b0;
   logic [MSB_AD_W-1:0] val_reg = 16'h0000;
   logic [MSB_AD_W-1:0] flt_reg = 16'hA5A5;
   initial begin
      address_strobe_n = 1'b1;
      data_strobe_n = 1'b1;
      read_not_write = 1'b1;
      byte_not_word = 1'b0;
      status = 4'h0;
   end
   always @(posedge clk) flt_reg <= ~flt_reg;
   assign ad_in = drv_reg ? val_reg : (!ad_oe_n ? ad_out : flt_reg);
   task automatic xact(input logic [3:0] st, input logic rnw, input logic bnw,
      input logic [15:0] addr, input logic [15:0] wd, input logic ds_on,
      output logic [15:0] rd, output int lat, output logic [1:0] pr);
      @(posedge clk);
      address_strobe_n <= 1'b0;
      status <= st;
      read_not_write <= rnw;
      byte_not_word <= bnw;
      drv_reg <= 1'b1;
      val_reg <= addr;
      repeat (2) @(posedge clk);
      address_strobe_n <= 1'b1;
      @(posedge clk);
      drv_reg <= !rnw;
      val_reg <= wd;
      @(posedge clk);
      data_strobe_n <= !ds_on;
      for (lat = 0; lat < 8; lat++) begin
         @(negedge clk);
         if (ad_oe_n === 1'b0) break;
      end
      rd = ad_in;
      pr = probe;
      @(posedge clk);
      data_strobe_n <= 1'b1;
      drv_reg <= 1'b0;
      repeat (2) @(negedge clk);
   endtask
   task automatic both_low(output logic [1:0] pr);
      @(posedge clk);
      address_strobe_n <= 1'b0;
      data_strobe_n <= 1'b0;
      @(negedge clk);
      pr = probe;
      @(posedge clk);
      address_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      @(negedge clk);
   endtask
endmodule

/* sim/tb_muxed_strobe_bus_slave_port.sv */
// Purpose: self-checking bench for the strobe bus slave port
// Assumes: request line has a pull-up; other requester driven here
// Notes: word bus under test, byte-wide copy watched; no long counts
module tb_muxed_strobe_bus_slave_port import msb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic irq_source = 1'b0;
   logic chain_enable_in = 1'b1;
   logic want_resource = 1'b0;
   logic other_req_n = 1'b1;
   logic resource_ack_in_n = 1'b1;
   logic bus_grant_in_n = 1'b1;
   logic as_n, ds_n, rnw, bnw, ad_oe_n, irq_oe_n, ch_out, req_oe_n, sense_n;
   logic ack_out_n, granted, irq_ack_n, bus_reset;
   logic [3:0] st;
   logic [15:0] ad_in, ad_out, rd, b_ad_out;
   logic [1:0] pr;
   int err_count = 0;
   int cmp_count = 0;
   int lat, mem_lat;
   always #10 clk = ~clk;
   // open-drain request line with pull-up
   assign sense_n = req_oe_n & other_req_n;
   msb_master_model bm (.clk(clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
      .probe({bus_reset, irq_ack_n}), .address_strobe_n(as_n), .data_strobe_n(ds_n),
      .read_not_write(rnw), .byte_not_word(bnw), .status(st), .ad_in(ad_in));
   msb_slave_port DUT (.clk(clk), .rst_n(rst_n), .address_strobe_n(as_n),
      .data_strobe_n(ds_n), .read_not_write(rnw), .byte_not_word(bnw), .status(st),
      .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .irq_source(irq_source),
      .irq_oe_n(irq_oe_n), .chain_enable_in(chain_enable_in), .chain_enable_out(ch_out),
      .want_resource(want_resource), .shared_resource_request_oe_n(req_oe_n),
      .shared_resource_sense_n(sense_n), .resource_ack_in_n(resource_ack_in_n),
      .resource_ack_out_n(ack_out_n), .bus_grant_in_n(bus_grant_in_n),
      .resource_granted(granted), .irq_acknowledge_n(irq_ack_n), .bus_reset(bus_reset));
   // byte-wide copy on the same bus; only its read data is watched
   msb_slave_port #(.WORD_BUS(0)) DUT8 (.clk(clk), .rst_n(rst_n), .address_strobe_n(as_n),
      .data_strobe_n(ds_n), .read_not_write(rnw), .byte_not_word(bnw), .status(st),
      .ad_in(ad_in), .ad_out(b_ad_out), .ad_oe_n(), .irq_source(irq_source), .irq_oe_n(),
      .chain_enable_in(chain_enable_in), .chain_enable_out(), .want_resource(want_resource),
      .shared_resource_request_oe_n(), .shared_resource_sense_n(sense_n),
      .resource_ack_in_n(resource_ack_in_n), .resource_ack_out_n(),
      .bus_grant_in_n(bus_grant_in_n), .resource_granted(), .irq_acknowledge_n(),
      .bus_reset());
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_mem();
      bm.xact(MSB_ST_MEM_NORMAL_DATA, 0, 0, 16'h0004, 16'h1234, 1, rd, lat, pr);
      bm.xact(MSB_ST_MEM_SYS_PROG, 0, 1, 16'h0005, 16'hEFEF, 1, rd, lat, pr);
      bm.xact(MSB_ST_MEM_SYS_DATA, 1, 0, 16'h0004, 16'h0000, 1, rd, mem_lat, pr);
      check(rd, 16'h12EF);
      check(b_ad_out, 16'h0034);
      check(mem_lat, 1);
      check(ad_oe_n, 1);
      bm.xact(MSB_ST_MEM_NORMAL_PROG, 0, 1, 16'h0004, 16'h5A5A, 1, rd, lat, pr);
      bm.xact(MSB_ST_MEM_NORMAL_DATA, 1, 0, 16'h0004, 16'h0000, 1, rd, lat, pr);
      check(rd, 16'h5AEF);
      check(b_ad_out, 16'h005A);
      $display("test mem done");
   endtask
   task automatic t_null();
      bm.xact(MSB_ST_INTERNAL, 1, 0, 16'h0004, 16'h0000, 1, rd, lat, pr);
      check(lat, 8);
      bm.xact(MSB_ST_REFRESH, 0, 0, 16'h0004, 16'hFFFF, 1, rd, lat, pr);
      bm.xact(MSB_ST_MEM_NORMAL_DATA, 0, 0, 16'h0004, 16'h0F0F, 0, rd, lat, pr);
      bm.xact(MSB_ST_MEM_NORMAL_DATA, 1, 0, 16'h0004, 16'h0000, 0, rd, lat, pr);
      check(lat, 8);
      bm.xact(MSB_ST_MEM_NORMAL_DATA, 1, 0, 16'h0004, 16'h0000, 1, rd, lat, pr);
      check(rd, 16'h5AEF);
      bm.xact(MSB_ST_IO, 1, 1, 16'hFF00, 16'h0000, 1, rd, lat, pr);
      check(lat, mem_lat + 1);
      $display("test null and io done");
   endtask
   task automatic t_irq();
      @(posedge clk) irq_source <= 1'b1;
      repeat (2) @(negedge clk);
      check(irq_oe_n, 0);
      check(ch_out, 0);
      @(posedge clk) chain_enable_in <= 1'b0;
      @(negedge clk);
      check(irq_oe_n, 1);
      check(ch_out, 0);
      @(posedge clk) chain_enable_in <= 1'b1;
      @(posedge clk) irq_source <= 1'b0;
      bm.xact(MSB_ST_IRQ_ACK, 1, 0, 16'h0000, 16'h0000, 1, rd, lat, pr);
      check(pr[0], 0);
      check(irq_ack_n, 1);
      check(irq_oe_n, 1);
      check(ch_out, 1);
      $display("test irq done");
   endtask
   task automatic t_res();
      @(posedge clk) want_resource <= 1'b1;
      resource_ack_in_n <= 1'b0;
      repeat (3) @(negedge clk);
      check(req_oe_n, 0);
      check(granted, 1);
      check(ack_out_n, 1);
      @(posedge clk) want_resource <= 1'b0;
      other_req_n <= 1'b0;
      repeat (3) @(negedge clk);
      check(granted, 0);
      check(ack_out_n, 0);
      @(posedge clk) other_req_n <= 1'b1;
      bm.both_low(pr);
      check(pr[1], 1);
      check(bus_reset, 0);
      $display("test resource and reset done");
   endtask
   initial begin
      repeat (15) @(posedge clk);
      @(negedge clk);
      check(ad_oe_n & irq_oe_n & req_oe_n & irq_ack_n, 1);
      @(posedge clk) rst_n <= 1'b1;
      t_mem();
      t_null();
      t_irq();
      t_res();
      wrap_up();
   end
endmodule
